/* rtl/mspc_defines.svh */
`ifndef MSPC_DEFINES_SVH
`define MSPC_DEFINES_SVH

// management bus address of this module (7-bit form)
`define MSPC_DEV_ADDR        7'h50

// register byte addresses on the management bus
`define MSPC_REG_STATUS      8'h02
`define MSPC_REG_FLAGS       8'h03
`define MSPC_REG_PWR_CTRL    8'h5d
`define MSPC_REG_OPTION      8'h5e
`define MSPC_REG_PCLASS      8'h81

// power class identifier field: position and value (above the low-power ceiling)
`define MSPC_PCLASS_LSB      6
`define MSPC_PCLASS_VAL      2'h3

// reset values of the user settings
`define MSPC_PWR_CTRL_RST    3'h0
`define MSPC_OPTION_RST      1'h0

// timing: figures in ns, counts in cycles of the 50 MHz clock
`define MSPC_CLK_PERIOD_NS   20
`define MSPC_T_RESET_MIN_NS  10000
`define MSPC_T_INIT_NS       2000000
`define MSPC_CNT_W           17
`define MSPC_RESET_MIN_CYC   ((`MSPC_T_RESET_MIN_NS + `MSPC_CLK_PERIOD_NS - 1) / `MSPC_CLK_PERIOD_NS)
`define MSPC_INIT_CYC        (`MSPC_T_INIT_NS / `MSPC_CLK_PERIOD_NS)

`endif

/* rtl/mspc_pkg.sv */
package mspc_pkg;

  // power mode decided from the pin and the control bits
  typedef enum logic [1:0] {
    MSPC_PM_LOW,
    MSPC_PM_LIMIT,
    MSPC_PM_HIGH
  } mspc_pmode_t;

  // power control byte, bit 2 down to bit 0
  typedef struct packed {
    logic class_en;
    logic pwr_set;
    logic override;
  } mspc_pwr_ctrl_t;

  // status bundle shown to the module's own datapath logic
  typedef struct packed {
    mspc_pmode_t pmode;
    logic        datapath_en;
    logic        init_pending;
    logic        reset_done;
  } mspc_status_t;

  // two-wire slave byte sequencer
  typedef enum logic [2:0] {
    MSPC_ST_IDLE,
    MSPC_ST_ADDR,
    MSPC_ST_ADDR_ACK,
    MSPC_ST_WR,
    MSPC_ST_WR_ACK,
    MSPC_ST_RD,
    MSPC_ST_RD_ACK
  } mspc_i2c_state_t;

endpackage

/* rtl/mspc_pin_sync.sv */
`timescale 1ns/10ps
`default_nettype none
// three-stage pin synchroniser; the level moves only when stages two and three agree
module mspc_pin_sync (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset,
  // asynchronous pin in, filtered level out
  input  wire logic i_pin,
  output logic      o_level
);

  logic s1;        // metastability catcher, read only by s2
  logic s2;        // second stage
  logic s3;        // third stage
  logic lvl;       // accepted level
  logic next_lvl;  // next accepted level

  // accept a change once two settled stages agree
  always_comb begin
    next_lvl = (s2 == s3) ? s3 : lvl;
  end

  // all pins idle high through pull-ups, so reset to one
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s1  <= 1'b1;
      s2  <= 1'b1;
      s3  <= 1'b1;
      lvl <= 1'b1;
    end else begin
      s1  <= i_pin;
      s2  <= s1;
      s3  <= s2;
      lvl <= next_lvl;
    end
  end

  assign o_level = lvl;

endmodule
`default_nettype wire

/* rtl/mspc_top.sv */
// Operation
// - selected module answers two-wire commands
// - deselected module never answers or acknowledges
// - long reset pulse restores all defaults
// - init interval starts at reset release
// - completion shown by interrupt, pending flag clear
// - power-up posts completion without reset pulse
// - pin without override, or override-plus-set, selects low power
// - class enable plus not-low selects high power
// - otherwise limit power mode
// - low power keeps management, datapath may stop
// - override and set bits reset to zero
// - class field reports above low-power ceiling
// - optional ignore of class enable, off
// - presence output grounded inside module
// - interrupt output low flags host condition
`timescale 1ns/10ps
`default_nettype none
`include "mspc_defines.svh"
module mspc_top #(
  parameter int INIT_CYCLES = `MSPC_INIT_CYC
) (
  // clock and reset
  input  wire logic           I_CLK,
  input  wire logic           I_RESET,
  // host control pins
  input  wire logic           I_MODULE_SELECT_N,
  input  wire logic           I_MODULE_RESET_N,
  input  wire logic           I_LOW_POWER_PIN,
  // two-wire management pins
  input  wire logic           I_SCL,
  output logic                O_SCL,
  output logic                O_SCL_OE,
  input  wire logic           I_SDA,
  output logic                O_SDA,
  output logic                O_SDA_OE,
  // host status pins
  output logic                O_MODULE_PRESENT_N,
  output logic                O_INTERRUPT_N,
  output logic                O_INTERRUPT_N_OE,
  // state towards the module datapath
  output mspc_pkg::mspc_status_t O_STATUS
);
  import mspc_pkg::*;

  localparam logic [`MSPC_CNT_W-1:0] INIT_CNT = INIT_CYCLES[`MSPC_CNT_W-1:0];
  localparam logic [`MSPC_CNT_W-1:0] RST_MIN  = `MSPC_CNT_W'(`MSPC_RESET_MIN_CYC);

  logic [4:0] pin_raw;   // raw pins to filter
  logic [4:0] pin_lvl;   // filtered levels
  logic       scl;       // filtered clock
  logic       sda;       // filtered data
  logic       sel_n;     // filtered select, low = selected
  logic       rst_lvl;   // filtered reset pin
  logic       lp_pin;    // filtered low-power pin

  assign pin_raw = {I_LOW_POWER_PIN, I_MODULE_RESET_N, I_MODULE_SELECT_N, I_SDA, I_SCL};

  // every host pin crosses into the clock domain the same way
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_sync
      mspc_pin_sync u_sync (
        .i_clk   (I_CLK),
        .i_reset (I_RESET),
        .i_pin   (pin_raw[g]),
        .o_level (pin_lvl[g])
      );
    end
  endgenerate

  assign scl     = pin_lvl[0];
  assign sda     = pin_lvl[1];
  assign sel_n   = pin_lvl[2];
  assign rst_lvl = pin_lvl[3];
  assign lp_pin  = pin_lvl[4];

  // ---------------- user settings and reset sequencing ----------------
  mspc_pwr_ctrl_t          pwr_ctrl, next_pwr_ctrl;           // power control byte
  logic                    ign_class, next_ign_class;         // ignore class enable option
  logic                    int_latch, next_int_latch;         // sticky reset-done flag
  logic                    init_pending, next_init_pending;   // data not ready
  logic [`MSPC_CNT_W-1:0]  low_cnt, next_low_cnt;             // cycles reset pin held low
  logic [`MSPC_CNT_W-1:0]  init_cnt, next_init_cnt;           // init countdown, 0 = idle
  logic                    armed, next_armed;                 // long reset seen, awaiting release
  mspc_pmode_t             pmode, next_pmode;                 // applied power mode
  logic                    dp_en, next_dp_en;                 // datapath allowed
  logic                    eff_lp;                            // low power request in force
  logic                    class_ok;                          // high power allowed
  logic                    long_rst;                          // reset pin low long enough

  // ---------------- two-wire slave ----------------
  mspc_i2c_state_t state, next_state;     // byte sequencer
  logic [7:0]      shift, next_shift;     // shift register
  logic [3:0]      bit_cnt, next_bit_cnt; // bits seen in this byte
  logic            rw, next_rw;           // read transfer
  logic            first, next_first;     // next written byte is the pointer
  logic            nack, next_nack;       // host refused further read data
  logic [7:0]      ptr, next_ptr;         // register pointer
  logic            sda_oe, next_sda_oe;   // pull data line low
  logic            scl_q, next_scl_q;     // previous clock level
  logic            sda_q, next_sda_q;     // previous data level
  logic            wr_en, next_wr_en;     // one-cycle register write
  logic [7:0]      wr_addr, next_wr_addr; // write address
  logic [7:0]      wr_data, next_wr_data; // write data
  logic            rd_en, next_rd_en;     // one-cycle register read
  logic [7:0]      rd_addr, next_rd_addr; // read address
  logic [7:0]      rd_val;                // byte at the pointer
  logic            start_c, stop_c;       // bus conditions
  logic            rise, fall;            // clock edges

  // register map seen by the host
  function automatic logic [7:0] read_byte(input logic [7:0] addr, input logic pend,
                                           input logic done, input mspc_pwr_ctrl_t pc,
                                           input logic opt);
    case (addr)
      `MSPC_REG_STATUS:   read_byte = {7'h00, pend};
      `MSPC_REG_FLAGS:    read_byte = {7'h00, done};
      `MSPC_REG_PWR_CTRL: read_byte = {5'h00, pc};
      `MSPC_REG_OPTION:   read_byte = {7'h00, opt};
      `MSPC_REG_PCLASS:   read_byte = {`MSPC_PCLASS_VAL, 6'h00};
      default:            read_byte = 8'h00;
    endcase
  endfunction

  assign rd_val  = read_byte(ptr, init_pending, int_latch, pwr_ctrl, ign_class);
  assign start_c = scl && scl_q && sda_q && !sda;
  assign stop_c  = scl && scl_q && !sda_q && sda;
  assign rise    = scl && !scl_q;
  assign fall    = !scl && scl_q;

  // byte sequencer; only one byte of lookahead, so reads see state at load time
  always_comb begin
    next_state   = state;
    next_shift   = shift;
    next_bit_cnt = bit_cnt;
    next_rw      = rw;
    next_first   = first;
    next_nack    = nack;
    next_ptr     = ptr;
    next_sda_oe  = sda_oe;
    next_scl_q   = scl;
    next_sda_q   = sda;
    next_wr_en   = 1'b0;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_rd_en   = 1'b0;
    next_rd_addr = rd_addr;
    if (sel_n) begin
      // deselected: drop any transfer and leave the line alone
      next_state  = MSPC_ST_IDLE;
      next_sda_oe = 1'b0;
    end else if (start_c) begin
      next_state   = MSPC_ST_ADDR;
      next_bit_cnt = 4'h0;
      next_sda_oe  = 1'b0;
    end else if (stop_c) begin
      next_state  = MSPC_ST_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      case (state)
        MSPC_ST_IDLE: begin
          next_sda_oe = 1'b0;
        end
        MSPC_ST_ADDR: begin
          if (rise) begin
            next_shift   = {shift[6:0], sda};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (fall && bit_cnt == 4'h8) begin
            if (shift[7:1] == `MSPC_DEV_ADDR) begin
              // our address: acknowledge
              next_state  = MSPC_ST_ADDR_ACK;
              next_rw     = shift[0];
              next_sda_oe = 1'b1;
            end else begin
              next_state = MSPC_ST_IDLE;
            end
          end
        end
        MSPC_ST_ADDR_ACK, MSPC_ST_RD_ACK: begin
          if (rise && state == MSPC_ST_RD_ACK) begin
            next_nack = sda;
          end else if (fall) begin
            next_bit_cnt = 4'h0;
            if (state == MSPC_ST_ADDR_ACK && !rw) begin
              // write transfer: pointer byte comes first
              next_state  = MSPC_ST_WR;
              next_sda_oe = 1'b0;
              next_first  = 1'b1;
            end else if (state == MSPC_ST_RD_ACK && nack) begin
              next_state  = MSPC_ST_IDLE;
              next_sda_oe = 1'b0;
            end else begin
              // load the next read byte and drive its top bit
              next_state   = MSPC_ST_RD;
              next_shift   = rd_val;
              next_sda_oe  = !rd_val[7];
              next_rd_en   = 1'b1;
              next_rd_addr = ptr;
              next_ptr     = ptr + 8'h01;
            end
          end
        end
        MSPC_ST_WR: begin
          if (rise) begin
            next_shift   = {shift[6:0], sda};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (fall && bit_cnt == 4'h8) begin
            next_state  = MSPC_ST_WR_ACK;
            next_sda_oe = 1'b1;
            if (first) begin
              next_ptr   = shift;
              next_first = 1'b0;
            end else begin
              next_wr_en   = 1'b1;
              next_wr_addr = ptr;
              next_wr_data = shift;
              next_ptr     = ptr + 8'h01;
            end
          end
        end
        MSPC_ST_WR_ACK: begin
          if (fall) begin
            next_state   = MSPC_ST_WR;
            next_sda_oe  = 1'b0;
            next_bit_cnt = 4'h0;
          end
        end
        MSPC_ST_RD: begin
          if (rise) begin
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (fall) begin
            if (bit_cnt == 4'h8) begin
              // release for the host acknowledge
              next_state  = MSPC_ST_RD_ACK;
              next_sda_oe = 1'b0;
            end else begin
              next_shift  = {shift[6:0], 1'b0};
              next_sda_oe = !shift[6];
            end
          end
        end
        default: begin
          next_state  = MSPC_ST_IDLE;
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  // two-wire slave registers
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      state   <= MSPC_ST_IDLE;
      shift   <= 8'h00;
      bit_cnt <= 4'h0;
      rw      <= 1'b0;
      first   <= 1'b0;
      nack    <= 1'b0;
      ptr     <= 8'h00;
      sda_oe  <= 1'b0;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      wr_en   <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
      rd_en   <= 1'b0;
      rd_addr <= 8'h00;
    end else begin
      state   <= next_state;
      shift   <= next_shift;
      bit_cnt <= next_bit_cnt;
      rw      <= next_rw;
      first   <= next_first;
      nack    <= next_nack;
      ptr     <= next_ptr;
      sda_oe  <= next_sda_oe;
      scl_q   <= next_scl_q;
      sda_q   <= next_sda_q;
      wr_en   <= next_wr_en;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      rd_en   <= next_rd_en;
      rd_addr <= next_rd_addr;
    end
  end

  // power decision is pure combinational so any input change applies next cycle
  assign class_ok = pwr_ctrl.class_en | ign_class;
  assign eff_lp   = pwr_ctrl.override ? pwr_ctrl.pwr_set : lp_pin;
  assign long_rst = !rst_lvl && (low_cnt == RST_MIN);

  // settings, reset sequencing and power mode
  always_comb begin
    next_pwr_ctrl     = pwr_ctrl;
    next_ign_class    = ign_class;
    next_int_latch    = int_latch;
    next_init_pending = init_pending;
    next_low_cnt      = low_cnt;
    next_init_cnt     = init_cnt;
    next_armed        = armed;
    next_pmode        = eff_lp ? MSPC_PM_LOW : (class_ok ? MSPC_PM_HIGH : MSPC_PM_LIMIT);
    next_dp_en        = !eff_lp;
    // host writes
    if (wr_en && wr_addr == `MSPC_REG_PWR_CTRL) begin
      next_pwr_ctrl = mspc_pwr_ctrl_t'(wr_data[2:0]);
    end
    if (wr_en && wr_addr == `MSPC_REG_OPTION) begin
      next_ign_class = wr_data[0];
    end
    // reading the flag byte tells the host the cause and clears it
    if (rd_en && rd_addr == `MSPC_REG_FLAGS) begin
      next_int_latch = 1'b0;
    end
    // init countdown; completion sets the flag after the flag-read clear, so set wins over a read
    if (init_cnt != '0) begin
      next_init_cnt = init_cnt - `MSPC_CNT_W'(1);
      if (init_cnt == `MSPC_CNT_W'(1)) begin
        next_init_pending = 1'b0;
        next_int_latch    = 1'b1;
      end
    end
    // reset pin: short glitches are ignored, a long pulse restores defaults
    if (!rst_lvl) begin
      if (low_cnt != RST_MIN) begin
        next_low_cnt = low_cnt + `MSPC_CNT_W'(1);
      end
      if (long_rst || armed) begin
        next_armed        = 1'b1;
        next_pwr_ctrl     = mspc_pwr_ctrl_t'(`MSPC_PWR_CTRL_RST);
        next_ign_class    = `MSPC_OPTION_RST;
        next_int_latch    = 1'b0;
        next_init_pending = 1'b1;
        next_init_cnt     = '0;
      end
    end else begin
      next_low_cnt = '0;
      if (armed) begin
        next_armed    = 1'b0;
        next_init_cnt = INIT_CNT;
      end
    end
  end

  // power-up starts the init countdown on its own
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      pwr_ctrl     <= mspc_pwr_ctrl_t'(`MSPC_PWR_CTRL_RST);
      ign_class    <= `MSPC_OPTION_RST;
      int_latch    <= 1'b0;
      init_pending <= 1'b1;
      low_cnt      <= '0;
      init_cnt     <= INIT_CNT;
      armed        <= 1'b0;
      pmode        <= MSPC_PM_LOW;
      dp_en        <= 1'b0;
    end else begin
      pwr_ctrl     <= next_pwr_ctrl;
      ign_class    <= next_ign_class;
      int_latch    <= next_int_latch;
      init_pending <= next_init_pending;
      low_cnt      <= next_low_cnt;
      init_cnt     <= next_init_cnt;
      armed        <= next_armed;
      pmode        <= next_pmode;
      dp_en        <= next_dp_en;
    end
  end

  // pins: open-drain lines only ever pull low
  assign O_SCL              = 1'b0;
  assign O_SCL_OE           = 1'b0;
  assign O_SDA              = 1'b0;
  assign O_SDA_OE           = sda_oe;
  assign O_MODULE_PRESENT_N = 1'b0;
  assign O_INTERRUPT_N      = 1'b0;
  assign O_INTERRUPT_N_OE   = int_latch;
  assign O_STATUS           = '{pmode: pmode, datapath_en: dp_en,
                                init_pending: init_pending, reset_done: int_latch};

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);

  a_deselect_quiet: assert property ($past(sel_n) |-> !sda_oe)
    else $error("data line driven while deselected");
  a_addr_ack_match: assert property ($rose(state == MSPC_ST_ADDR_ACK) |->
    sda_oe && $past(shift[7:1]) == `MSPC_DEV_ADDR && !$past(sel_n))
    else $error("address acknowledge without match or select");
  a_present_gnd: assert property (O_MODULE_PRESENT_N == 1'b0 && !O_SCL_OE)
    else $error("presence output not grounded");
  a_done_irq: assert property ($fell(init_pending) |-> int_latch && O_INTERRUPT_N_OE)
    else $error("reset completion without interrupt");
  a_irq_not_pending: assert property (O_INTERRUPT_N_OE |-> !init_pending)
    else $error("interrupt while init still pending");
  a_low_mode: assert property ((lp_pin && !pwr_ctrl.override) ||
    (pwr_ctrl.override && pwr_ctrl.pwr_set) |=> pmode == MSPC_PM_LOW)
    else $error("low power not selected");
  a_high_mode: assert property (!eff_lp && (pwr_ctrl.class_en || ign_class)
    |=> pmode == MSPC_PM_HIGH)
    else $error("high power not selected");
  a_limit_mode: assert property (!eff_lp && !pwr_ctrl.class_en && !ign_class
    |=> pmode == MSPC_PM_LIMIT)
    else $error("limit power not selected");
  a_dp_off_low: assert property (pmode == MSPC_PM_LOW |-> !dp_en)
    else $error("datapath enabled in low power");
  a_long_reset: assert property (long_rst |=> pwr_ctrl == '0 && !ign_class &&
    init_pending && !int_latch)
    else $error("long reset did not restore defaults");
  a_init_start: assert property (rst_lvl && armed |=> init_cnt == INIT_CNT && !armed)
    else $error("init interval not started at release");
  a_power_up: assert property ($past(I_RESET) |-> init_cnt == INIT_CNT && init_pending)
    else $error("power-up init not started");
  a_irq_hold: assert property (int_latch && !(rd_en && rd_addr == `MSPC_REG_FLAGS)
    && !long_rst |=> int_latch)
    else $error("interrupt dropped before flag read");

endmodule
`default_nettype wire

/* tb/mspc_host.sv */
`timescale 1ns/10ps
`default_nettype none
// host board controller: open-drain two-wire master, pull-ups on both lines
module mspc_host (
  // clock
  input  wire logic i_clk,
  // module pulling data low
  input  wire logic i_sda_oe,
  // resolved wire levels
  output logic      o_scl,
  output logic      o_sda
);
  logic scl_pull; // host pulls clock low
  logic sda_pull; // host pulls data low
  // released lines float up to the pull-up level
  assign o_scl = !scl_pull;
  assign o_sda = !(sda_pull | i_sda_oe);
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  // every phase lasts 12 cycles, so the slave's 4-cycle filter and 5-cycle reply fit
  task automatic hold(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // start or repeated start: data falls while clock is high
  task automatic start();
    sda_pull <= 1'b0;
    hold(12);
    scl_pull <= 1'b0;
    hold(12);
    sda_pull <= 1'b1;
    hold(12);
    scl_pull <= 1'b1;
    hold(12);
  endtask
  // stop: data rises while clock is high
  task automatic stop();
    sda_pull <= 1'b1;
    hold(12);
    scl_pull <= 1'b0;
    hold(12);
    sda_pull <= 1'b0;
    hold(12);
  endtask
  // one clock pulse; data is set while clock is low and read while high
  task automatic xfer_bit(input logic b, output logic r);
    sda_pull <= !b;
    hold(12);
    scl_pull <= 1'b0;
    hold(12);
    r = o_sda;
    scl_pull <= 1'b1;
    hold(12);
  endtask
  // byte out msb first, then the slave's acknowledge slot
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(d[i], r);
    end
    xfer_bit(1'b1, r);
    ack = !r;
  endtask
  // register write: device address, pointer, data
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, output logic ack);
    logic k0;
    logic k1;
    logic k2;
    start();
    send(8'ha0, k0);
    send(a, k1);
    send(d, k2);
    stop();
    ack = k0 & k1 & k2;
  endtask
  // register read: pointer write, repeated start, one byte, host nack ends it
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic ack);
    logic k0;
    logic k1;
    logic k2;
    logic r;
    start();
    send(8'ha0, k0);
    send(a, k1);
    start();
    send(8'ha1, k2);
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'b1, r);
      d[i] = r;
    end
    xfer_bit(1'b1, r);
    stop();
    ack = k0 & k1 & k2;
  endtask
endmodule
`default_nettype wire

/* tb/mspc_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module mspc_top_tb;
  import mspc_pkg::*;
  localparam int INIT = 20; // shortened init countdown
  logic         clk;
  logic         rst;
  logic         sel_n;
  logic         rst_n;
  logic         lp_pin;
  logic         scl;
  logic         sda;
  logic         sda_oe;
  logic         scl_out;
  logic         scl_oe;
  logic         sda_out;
  logic         present_n;
  logic         int_n;
  logic         int_oe;
  mspc_status_t status;
  int           failures;
  int           n_compared;
  logic [7:0]   rd;
  logic         ack;
  logic [3:0]   pick;
  logic [7:0]   addr [4] = '{8'h5d, 8'h5e, 8'h81, 8'h03};
  logic [7:0]   want [4] = '{8'h00, 8'h00, 8'hc0, 8'h01};

  mspc_top #(.INIT_CYCLES(INIT)) u_dut (
    .I_CLK(clk), .I_RESET(rst), .I_MODULE_SELECT_N(sel_n), .I_MODULE_RESET_N(rst_n),
    .I_LOW_POWER_PIN(lp_pin), .I_SCL(scl), .O_SCL(scl_out), .O_SCL_OE(scl_oe), .I_SDA(sda),
    .O_SDA(sda_out), .O_SDA_OE(sda_oe), .O_MODULE_PRESENT_N(present_n),
    .O_INTERRUPT_N(int_n), .O_INTERRUPT_N_OE(int_oe), .O_STATUS(status));
  mspc_host u_host (.i_clk(clk), .i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = !clk;
  end
  // expected mode: low wins, then the class enable picks high over limit
  function automatic logic [7:0] exp_mode(input logic pin, input logic [2:0] c);
    if ((pin && !c[0]) || (c[0] && c[1])) return 8'(MSPC_PM_LOW);
    return c[2] ? 8'(MSPC_PM_HIGH) : 8'(MSPC_PM_LIMIT);
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // bounded wait for the completion interrupt; running out counts as a mismatch
  task automatic wait_int(input int n);
    int k;
    k = 0;
    while (int_oe !== 1'b1 && k < n) begin
      @(posedge clk);
      k++;
    end
    if (k >= n) begin
      failures++;
      test_done();
    end
  endtask

  initial begin
    failures = 0;
    n_compared = 0;
    rst = 1'b1;
    sel_n = 1'b1;
    rst_n = 1'b1;
    lp_pin = 1'b1;
    void'($urandom(97));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // power-up completion arrives with no reset pulse; status ignored until then
    wait_int(INIT + 50);
    check({7'h0, status.init_pending}, 8'h00);
    check({7'h0, int_n | !int_oe}, 8'h00);
    check({7'h0, status.reset_done}, 8'h01);
    check({5'h0, scl_out, scl_oe, sda_out}, 8'h00);
    check({7'h0, present_n}, 8'h00);
    sel_n <= 1'b0;
    u_host.hold(20);
    // defaults and identifiers; the flag read is how the host finds the cause
    for (int i = 0; i < 4; i++) begin
      u_host.rd_reg(addr[i], rd, ack);
      check(rd, want[i]);
      check({7'h0, ack}, 8'h01);
      // the interrupt stands until the flag byte, read last, is fetched
      check({7'h0, int_oe}, 8'(i < 3));
    end
    check({7'h0, int_oe}, 8'h00);
    // deselected module must stay silent and ignore the write
    sel_n <= 1'b1;
    u_host.hold(20);
    u_host.wr_reg(8'h5d, 8'h07, ack);
    check({7'h0, ack}, 8'h00);
    sel_n <= 1'b0;
    u_host.hold(20);
    u_host.rd_reg(8'h5d, rd, ack);
    check(rd, 8'h00);
    // every pin and control combination, then random ones, applied without reset
    for (int i = 0; i < 28; i++) begin
      pick = (i < 16) ? 4'(i) : 4'($urandom);
      lp_pin <= pick[3];
      u_host.wr_reg(8'h5d, {5'h00, pick[2:0]}, ack);
      u_host.hold(10);
      check({6'h0, status.pmode}, exp_mode(pick[3], pick[2:0]));
      check({7'h0, status.datapath_en},
            8'(exp_mode(pick[3], pick[2:0]) != 8'(MSPC_PM_LOW)));
      check({7'h0, ack}, 8'h01);
    end
    // ignore option lets high power through with the class enable clear
    lp_pin <= 1'b0;
    u_host.wr_reg(8'h5e, 8'h01, ack);
    u_host.wr_reg(8'h5d, 8'h00, ack);
    u_host.hold(10);
    check({6'h0, status.pmode}, 8'(MSPC_PM_HIGH));
    // long reset pulse: defaults return, countdown starts at release
    u_host.wr_reg(8'h5d, 8'h03, ack);
    rst_n <= 1'b0;
    u_host.hold(520);
    check({7'h0, status.init_pending}, 8'h01);
    rst_n <= 1'b1;
    u_host.hold(10);
    check({7'h0, int_oe}, 8'h00);
    wait_int(INIT + 50);
    u_host.rd_reg(8'h5d, rd, ack);
    check(rd, 8'h00);
    // option is back off, so pin low and class enable clear give limit power
    u_host.rd_reg(8'h5e, rd, ack);
    check(rd, 8'h00);
    check({6'h0, status.pmode}, 8'(MSPC_PM_LIMIT));
    test_done();
  end
endmodule
`default_nettype wire
